// ==== common/tdc_pkg.sv ====
// Register indices, field layouts and timing counts of the timer with input capture.
package tdc_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int CNT_W = 8;
	localparam int NIB_W = 4;
	localparam int PRE_W = 7;
	// Register indices; the byte address of each register is four times its index.
	localparam logic [7:0] IDX_PIN_FUNC = 8'h0A;
	localparam logic [7:0] IDX_CLK_GATE = 8'h0D;
	localparam logic [7:0] IDX_MODE1 = 8'h18;
	localparam logic [7:0] IDX_MODE2 = 8'h19;
	localparam logic [7:0] IDX_DATA_LO = 8'h1A;
	localparam logic [7:0] IDX_DATA_HI = 8'h1B;
	localparam logic [7:0] IDX_FLAGS = 8'h1C;
	localparam logic [7:0] IDX_IRQ_STAT = 8'h1D;
	localparam logic [7:0] IDX_IRQ_MASK = 8'h1E;
	localparam int IDX_LSB = 2;
	localparam int IDX_MSB = 9;
	// First mode register: bit 3 reload, bits 2..0 input clock source.
	localparam int M1_RELOAD_BIT = 3;
	localparam int M1_CLK_MSB = 2;
	localparam logic [2:0] CLK_EXT_EVENT = 3'h7;
	// Second mode register: bit 2 capture enable, bits 1..0 edge select.
	localparam int M2_CAP_BIT = 2;
	localparam int M2_EDGE_MSB = 1;
	localparam logic [1:0] EDGE_FALL = 2'h1;
	localparam logic [1:0] EDGE_RISE = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;
	localparam int PIN_EVENT_BIT = 0;
	localparam int GATE_STOP_BIT = 0;
	// Flag register bits, written with 0 to clear.
	localparam int FLAG_IRQ = 0;
	localparam int FLAG_CSF = 1;
	localparam int FLAG_CEF = 2;
	localparam int FLAG_W = 3;
	// Interrupt status and mask bits.
	localparam int EV_OVF = 0;
	localparam int EV_CAP = 1;
	localparam int EV_ERR = 2;
	localparam int EV_W = 3;
	localparam logic [3:0] MODE1_RST = 4'h0;
	localparam logic [2:0] MODE2_RST = 3'h0;
	localparam logic [3:0] NIB_RST = 4'h0;
	localparam logic [7:0] CNT_ZERO = 8'h00;
	localparam logic [7:0] CNT_MAX = 8'hFF;
	localparam logic [1:0] MODE_DELAY_CYC = 2'h2;
	localparam logic [1:0] DLY_ONE = 2'h1;
	localparam logic [1:0] DLY_IDLE = 2'h0;
	localparam logic [DATA_W-1:0] RDATA_ZERO = 32'h0000_0000;
endpackage : tdc_pkg

// ==== hdl/tdc_timer.sv ====
// Eight-bit up-counting timer with event counting and input capture, reached over APB.
// Function
// R1 - Capture edge: falling, rising or both
// R2 - Edge latches count, sets request and status
// R3 - Capture clears counter, counting continues
// R4 - Error on edge while status set, overflow
// R5 - Status and error cleared by reset, zero-write
// R6 - Entering capture mode clears the counter
// R7 - First mode register: reload, clock, prescale
// R8 - First mode change applies two cycles later
// R9 - Software picks internal clock for capture
// R10 - Second mode register: edge and capture enable
// R11 - Captured value independent of nibble read order
// R12 - Split preload register, low nibble resets zero
// R13 - Split read register for count or capture
// R14 - Pin function selects event input
// R15 - Clock gate register stops the timer
// R16 - Counter loads preload, increments on clock
// R17 - Overflow reloads or restarts from zero
// R18 - Overflow sets request flag, software clears
// R19 - Event pin synchronised before edge detection
`timescale 1ns/1ps
`default_nettype none
module tdc_timer (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic ce_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [tdc_pkg::ADDR_W-1:0] paddr_in,
	input wire logic [tdc_pkg::DATA_W-1:0] pwdata_in,
	output logic [tdc_pkg::DATA_W-1:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic event_trigger_pin_in,
	output logic irq_out
);
	import tdc_pkg::*;

	logic [7:0] idx;
	logic hit;
	logic setup_rd;
	logic acc_wr;
	logic acc_rd;
	logic [3:0] pin_function_select_2_ff;
	logic [3:0] module_clock_gate_1_ff;
	logic [3:0] mode1_pend_ff;
	logic [3:0] timer_mode_clock_select_ff;
	logic [1:0] mode1_dly_ff;
	logic [2:0] timer_mode_edge_capture_ff;
	logic [3:0] preload_low_nibble_ff;
	logic [3:0] preload_high_nibble_ff;
	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] cap_ff;
	logic [NIB_W-1:0] hold_hi_ff;
	logic [PRE_W-1:0] pre_ff;
	logic [PRE_W-1:0] pre_tick;
	logic [FLAG_W-1:0] flags_ff;
	logic [EV_W-1:0] irq_stat_ff;
	logic [EV_W-1:0] irq_mask_ff;
	logic [DATA_W-1:0] prdata_ff;
	logic [DATA_W-1:0] nxt_rdata;
	logic ev_sync1_ff;
	logic ev_sync2_ff;
	logic ev_prev_ff;
	logic rise;
	logic fall;
	logic edge_hit;
	logic cap_en;
	logic running;
	logic tick;
	logic capture;
	logic overflow;
	logic cap_error;
	logic cap_start;
	logic load;
	logic [CNT_W-1:0] preload;
	logic [FLAG_W-1:0] nxt_flags;
	logic [EV_W-1:0] events;

	// APB decode; the slave never waits, except that a frozen block holds the bus off.
	assign idx = paddr_in[IDX_MSB:IDX_LSB];
	assign hit = (idx == IDX_PIN_FUNC) || (idx == IDX_CLK_GATE) || (idx == IDX_MODE1) ||
		(idx == IDX_MODE2) || (idx == IDX_DATA_LO) || (idx == IDX_DATA_HI) ||
		(idx == IDX_FLAGS) || (idx == IDX_IRQ_STAT) || (idx == IDX_IRQ_MASK);
	assign setup_rd = ce_in && psel_in && !penable_in && !pwrite_in;
	assign acc_wr = ce_in && psel_in && penable_in && pwrite_in && hit;
	assign acc_rd = ce_in && psel_in && penable_in && !pwrite_in && hit;
	assign pready_out = ce_in;
	assign pslverr_out = psel_in && penable_in && !hit;
	assign prdata_out = prdata_ff;

	assign cap_en = timer_mode_edge_capture_ff[M2_CAP_BIT];
	assign running = !module_clock_gate_1_ff[GATE_STOP_BIT]; // R15
	assign preload = {preload_high_nibble_ff, preload_low_nibble_ff};

	// Read data is formed in the setup phase so that it comes from a flip-flop.
	always_comb begin
		nxt_rdata = RDATA_ZERO;
		case (idx)
			IDX_DATA_LO: nxt_rdata[NIB_W-1:0] = cap_en ? cap_ff[NIB_W-1:0] : cnt_ff[NIB_W-1:0]; // R13
			IDX_DATA_HI: nxt_rdata[NIB_W-1:0] = cap_en ? cap_ff[CNT_W-1:NIB_W] : hold_hi_ff; // R11
			IDX_FLAGS: nxt_rdata[FLAG_W-1:0] = flags_ff;
			IDX_IRQ_STAT: nxt_rdata[EV_W-1:0] = irq_stat_ff;
			IDX_IRQ_MASK: nxt_rdata[EV_W-1:0] = irq_mask_ff;
			default: nxt_rdata = RDATA_ZERO;
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			prdata_ff <= RDATA_ZERO;
		end else if (setup_rd) begin
			prdata_ff <= nxt_rdata;
		end
	end

	// The upper count nibble is frozen when the lower one is read, so a count read is coherent.
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			hold_hi_ff <= NIB_RST;
		end else if (setup_rd && idx == IDX_DATA_LO) begin
			hold_hi_ff <= cnt_ff[CNT_W-1:NIB_W];
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			pin_function_select_2_ff <= NIB_RST; // R14
			module_clock_gate_1_ff <= NIB_RST; // R15
		end else if (acc_wr) begin
			if (idx == IDX_PIN_FUNC) begin
				pin_function_select_2_ff <= pwdata_in[NIB_W-1:0]; // R14
			end
			if (idx == IDX_CLK_GATE) begin
				module_clock_gate_1_ff <= pwdata_in[NIB_W-1:0]; // R15
			end
		end
	end

	// A new first mode is parked and only steers the counter two cycles after the write.
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			mode1_pend_ff <= MODE1_RST; // R7
			timer_mode_clock_select_ff <= MODE1_RST; // R7
			mode1_dly_ff <= DLY_IDLE;
		end else if (ce_in) begin
			if (acc_wr && idx == IDX_MODE1) begin
				mode1_pend_ff <= pwdata_in[NIB_W-1:0];
				mode1_dly_ff <= MODE_DELAY_CYC; // R8
			end else if (mode1_dly_ff != DLY_IDLE) begin
				mode1_dly_ff <= mode1_dly_ff - DLY_ONE;
				if (mode1_dly_ff == DLY_ONE) begin
					timer_mode_clock_select_ff <= mode1_pend_ff; // R8
				end
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			timer_mode_edge_capture_ff <= MODE2_RST; // R10
		end else if (acc_wr && idx == IDX_MODE2) begin
			timer_mode_edge_capture_ff <= pwdata_in[M2_CAP_BIT:0]; // R10
		end
	end

	assign cap_start = acc_wr && idx == IDX_MODE2 && pwdata_in[M2_CAP_BIT] && !cap_en;
	assign load = acc_wr && idx == IDX_DATA_HI;

	// The upper preload nibble has no defined reset in the device; it is cleared here anyway.
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			preload_low_nibble_ff <= NIB_RST; // R12
			preload_high_nibble_ff <= NIB_RST;
		end else if (acc_wr) begin
			if (idx == IDX_DATA_LO) begin
				preload_low_nibble_ff <= pwdata_in[NIB_W-1:0]; // R12
			end
			if (idx == IDX_DATA_HI) begin
				preload_high_nibble_ff <= pwdata_in[NIB_W-1:0]; // R12
			end
		end
	end

	// Event pin: two flip-flops against metastability, a third for the edge.
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			ev_sync1_ff <= 1'b0;
			ev_sync2_ff <= 1'b0;
			ev_prev_ff <= 1'b0;
		end else if (ce_in) begin
			ev_sync1_ff <= event_trigger_pin_in; // R19
			ev_sync2_ff <= ev_sync1_ff; // R19
			ev_prev_ff <= ev_sync2_ff;
		end
	end

	assign rise = ev_sync2_ff && !ev_prev_ff;
	assign fall = !ev_sync2_ff && ev_prev_ff;

	always_comb begin
		edge_hit = 1'b0;
		if (pin_function_select_2_ff[PIN_EVENT_BIT] && ce_in && running) begin
			case (timer_mode_edge_capture_ff[M2_EDGE_MSB:0])
				EDGE_FALL: edge_hit = fall; // R1
				EDGE_RISE: edge_hit = rise; // R1
				EDGE_BOTH: edge_hit = rise || fall; // R1
				default: edge_hit = 1'b0;
			endcase
		end
	end

	// Prescaler: tap k pulses once every 2^(k+1) cycles.
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			pre_ff <= '0;
		end else if (ce_in && running) begin
			pre_ff <= pre_ff + PRE_W'(1);
		end
	end

	genvar k;
	generate
		for (k = 0; k < PRE_W; k++) begin : g_tap
			assign pre_tick[k] = &pre_ff[k:0];
		end
	endgenerate

	// In capture mode the external event source is never a count source, even if selected.
	always_comb begin
		tick = 1'b0;
		if (ce_in && running) begin
			if (timer_mode_clock_select_ff[M1_CLK_MSB:0] == CLK_EXT_EVENT) begin
				tick = edge_hit && !cap_en;
			end else begin
				tick = pre_tick[timer_mode_clock_select_ff[M1_CLK_MSB:0]]; // R16
			end
		end
	end

	assign capture = cap_en && edge_hit; // R2
	assign overflow = tick && cnt_ff == CNT_MAX; // R17
	assign cap_error = (capture && flags_ff[FLAG_CSF]) || (cap_en && overflow); // R4

	// A capture outranks an overflow in the same cycle: the count restarts from zero.
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			cnt_ff <= CNT_ZERO;
		end else if (ce_in) begin
			if (cap_start) begin
				cnt_ff <= CNT_ZERO; // R6
			end else if (load) begin
				cnt_ff <= {pwdata_in[NIB_W-1:0], preload_low_nibble_ff}; // R16
			end else if (capture) begin
				cnt_ff <= CNT_ZERO; // R3
			end else if (overflow) begin
				cnt_ff <= timer_mode_clock_select_ff[M1_RELOAD_BIT] ? preload : CNT_ZERO; // R17
			end else if (tick) begin
				cnt_ff <= cnt_ff + CNT_W'(1); // R16
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			cap_ff <= CNT_ZERO;
		end else if (capture) begin
			cap_ff <= cnt_ff; // R2
		end
	end

	// Writing 0 clears a flag; a hardware set in the same cycle wins.
	always_comb begin
		nxt_flags = flags_ff;
		if (acc_wr && idx == IDX_FLAGS) begin
			nxt_flags = flags_ff & pwdata_in[FLAG_W-1:0]; // R5
		end
		if (overflow || capture) begin
			nxt_flags[FLAG_IRQ] = 1'b1; // R18
		end
		if (capture) begin
			nxt_flags[FLAG_CSF] = 1'b1; // R2
		end
		if (cap_error) begin
			nxt_flags[FLAG_CEF] = 1'b1; // R4
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			flags_ff <= '0; // R5
		end else if (ce_in) begin
			flags_ff <= nxt_flags;
		end
	end

	// Interrupt status clears only the bits that the read actually returned.
	assign events = {cap_error, capture, overflow};

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			irq_stat_ff <= '0;
		end else if (ce_in) begin
			if (acc_rd && idx == IDX_IRQ_STAT) begin
				irq_stat_ff <= (irq_stat_ff & ~prdata_ff[EV_W-1:0]) | events;
			end else begin
				irq_stat_ff <= irq_stat_ff | events;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			irq_mask_ff <= '0;
		end else if (acc_wr && idx == IDX_IRQ_MASK) begin
			irq_mask_ff <= pwdata_in[EV_W-1:0];
		end
	end

	assign irq_out = |(irq_stat_ff & irq_mask_ff);

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);

	a_capture_latch: assert property (capture // R2
		|=> cap_ff == $past(cnt_ff) && flags_ff[FLAG_CSF] && flags_ff[FLAG_IRQ])
		else $error("capture did not latch count or set flags");
	a_capture_restart: assert property (capture && !cap_start && !load |=> cnt_ff == CNT_ZERO) // R3
		else $error("counter not cleared by capture");
	a_error_on_repeat: assert property (capture && flags_ff[FLAG_CSF] |=> flags_ff[FLAG_CEF]) // R4
		else $error("repeat capture did not raise error flag");
	a_error_on_wrap: assert property (cap_en && overflow |=> flags_ff[FLAG_CEF]) // R4
		else $error("overflow in capture mode did not raise error flag");
	a_flag_zero_write: assert property (acc_wr && idx == IDX_FLAGS // R5
		&& !pwdata_in[FLAG_CSF] && !capture |=> !flags_ff[FLAG_CSF])
		else $error("status flag survived a zero write");
	a_capture_entry: assert property (cap_start |=> cnt_ff == CNT_ZERO) // R6
		else $error("counter not cleared on entering capture mode");
	a_mode_delay: assert property (acc_wr && idx == IDX_MODE1 // R8
		##1 ce_in && !(acc_wr && idx == IDX_MODE1)
		##1 ce_in && !(acc_wr && idx == IDX_MODE1)
		|-> timer_mode_clock_select_ff == $past(timer_mode_clock_select_ff)
		##1 timer_mode_clock_select_ff == $past(pwdata_in[NIB_W-1:0], 3))
		else $error("first mode not applied exactly two cycles after write");
	a_wrap_value: assert property (overflow && !capture && !cap_start && !load // R17
		|=> cnt_ff == ($past(timer_mode_clock_select_ff[M1_RELOAD_BIT]) ? $past(preload) : CNT_ZERO))
		else $error("wrong value after overflow");
	a_wrap_request: assert property (overflow |=> flags_ff[FLAG_IRQ]) // R18
		else $error("overflow did not set request flag");
	a_single_capture: assert property (capture |=> !capture) // R19
		else $error("one edge produced two captures");
	a_gate_freeze: assert property (!running && !cap_start && !load |=> $stable(cnt_ff)) // R15
		else $error("counter moved while clock gated");
	// Only steps that no higher-priority event overrides are checked for a plain increment.
	a_count_step: assert property (tick && !overflow && !capture && !cap_start && !load // R16
		|=> cnt_ff == $past(cnt_ff) + CNT_W'(1))
		else $error("counter did not step by one on a tick");
	a_load_value: assert property (load && !cap_start // R12
		|=> cnt_ff == {$past(pwdata_in[NIB_W-1:0]), $past(preload_low_nibble_ff)})
		else $error("counter not loaded from the preload nibbles");
	a_edge_select: assert property (capture // R1
		|-> (rise && |(timer_mode_edge_capture_ff[M2_EDGE_MSB:0] & EDGE_RISE))
		|| (fall && |(timer_mode_edge_capture_ff[M2_EDGE_MSB:0] & EDGE_FALL)))
		else $error("capture on an edge that was not selected");
	a_pin_unassigned: assert property (!pin_function_select_2_ff[PIN_EVENT_BIT] // R14
		|-> !capture)
		else $error("capture while the pin is not the event input");

	c_capture: cover property (capture ##[1:300] capture);
	c_cap_error: cover property (capture && flags_ff[FLAG_CSF]);
	c_reload_wrap: cover property (overflow && timer_mode_clock_select_ff[M1_RELOAD_BIT]);
	c_irq_raise: cover property (!irq_out ##1 irq_out);
	c_capture_entry: cover property (cap_start);
endmodule : tdc_timer
`default_nettype wire

// ==== tb/tdc_event_src.sv ====
// Edge source that stands in for whatever drives the trigger pin.
`timescale 1ns/1ps
`default_nettype none
module tdc_event_src (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic level_in,
	output logic pin_out
);
	logic [1:0] hold_ff;
	// Each level is held two clocks at least, so both-edge detection never sees a runt.
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			pin_out <= 1'b0;
			hold_ff <= 2'h0;
		end else if (hold_ff != 2'h0) begin
			hold_ff <= hold_ff - 2'h1;
		end else if (level_in != pin_out) begin
			pin_out <= level_in;
			hold_ff <= 2'h2;
		end
	end
endmodule : tdc_event_src
`default_nettype wire

// ==== tb/tb_tdc_timer.sv ====
// Self-checking bench of the capture timer with an APB master and a flag model.
`timescale 1ns/1ps
`default_nettype none
module tb_tdc_timer;
	import tdc_pkg::*;
	logic clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [ADDR_W-1:0] paddr = 12'h000;
	logic [DATA_W-1:0] pwdata = 32'h0;
	logic [DATA_W-1:0] prdata;
	logic [DATA_W-1:0] rd;
	logic pready;
	logic pslverr;
	logic err;
	logic pin;
	logic lvl = 1'b0;
	logic ce = 1'b1;
	int c;
	logic irq;
	logic [31:0] seed = 32'h4206CA8E;
	int failures = 0;
	int num_checks = 0;
	int m_flags;
	int v;
	tdc_timer i_dut (.clk_in(clk_in), .reset_in(reset_in), .ce_in(ce), .psel_in(psel),
		.penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
		.prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
		.event_trigger_pin_in(pin), .irq_out(irq));
	tdc_event_src i_src (.clk_in(clk_in), .reset_in(reset_in), .level_in(lvl), .pin_out(pin));
	initial begin
		forever #20 clk_in = ~clk_in;
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs
	task automatic finish_test();
		$display("checks=%0d failures=%0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : finish_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// One APB transfer; the leading edge keeps a released psel from being raised in one step.
	task automatic apb(input logic wr_en, input logic [7:0] idx, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clk_in);
		psel <= 1'b1;
		pwr <= wr_en;
		paddr <= {2'h0, idx, 2'h0};
		pwdata <= wd;
		@(posedge clk_in);
		pen <= 1'b1;
		do begin
			@(posedge clk_in);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) begin
			failures++;
			finish_test();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb
	task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 32'h0);
		chk(rd, exp);
	endtask : rchk
	task automatic pin_to(input logic lv);
		@(posedge clk_in);
		lvl <= lv;
		repeat (8) @(posedge clk_in);
	endtask : pin_to
	initial begin
		repeat (5) @(posedge clk_in);
		reset_in <= 1'b0;
		for (int i = 8'h0A; i <= 8'h1E; i++) begin
			apb(1'b0, 8'(i), 32'h0);
			v = (i inside {8'h0A, 8'h0D, [8'h18:8'h1E]}) ? 0 : 1;
			// Mode 0 ticks every second cycle from reset, and the j-th read samples the count
			// after 3j+1 cycles; the upper nibble shows what the previous lower read froze.
			c = (i == 8'h1A) ? (3 * (i - 8'h0A) + 1) / 2 % 16 : 0;
			c = (i == 8'h1B) ? (3 * (i - 8'h0B) + 1) / 2 / 16 : c;
			chk(rd, 32'(c));
			chk({31'h0, err}, 32'(v));
		end
		$display("end of reset test");
		// An external clock with the pin unassigned freezes the counter without gating it.
		apb(1'b1, IDX_MODE1, 32'h7);
		for (int k = 0; k < 4; k++) begin
			seed = xs(seed);
			apb(1'b1, IDX_DATA_LO, {28'h0, seed[3:0]});
			apb(1'b1, IDX_DATA_HI, {28'h0, seed[7:4]});
			rchk(IDX_DATA_LO, {28'h0, seed[3:0]});
			rchk(IDX_DATA_HI, {28'h0, seed[7:4]});
		end
		$display("end of load test");
		for (int r = 1; r >= 0; r--) begin
			apb(1'b1, IDX_MODE1, 32'(r * 8));
			apb(1'b1, IDX_DATA_LO, 32'hE);
			apb(1'b1, IDX_DATA_HI, 32'hF);
			repeat (12) @(posedge clk_in);
			apb(1'b1, IDX_MODE1, 32'(r * 8 + 7));
			apb(1'b0, IDX_DATA_LO, 32'h0);
			v = rd[3:0];
			apb(1'b0, IDX_DATA_HI, 32'h0);
			v = v + rd[3:0] * 16;
			chk(32'(r ? v >= 8'hFE : v < 8'h20), 32'h1);
		end
		m_flags = 1;
		rchk(IDX_FLAGS, 32'(m_flags));
		rchk(IDX_IRQ_STAT, 32'h1);
		rchk(IDX_IRQ_STAT, 32'h0);
		apb(1'b1, IDX_FLAGS, 32'h0);
		rchk(IDX_FLAGS, 32'h0);
		$display("end of overflow test");
		apb(1'b1, IDX_PIN_FUNC, 32'h1);
		apb(1'b1, IDX_MODE1, 32'h6);
		for (int s = 0; s < 4; s++) begin
			apb(1'b1, IDX_MODE2, 32'(4 + s));
			for (int e = 1; e >= 0; e--) begin
				apb(1'b1, IDX_FLAGS, 32'h0);
				pin_to(e[0]);
				m_flags = (s == (e ? EDGE_RISE : EDGE_FALL) || s == EDGE_BOTH) ? 3 : 0;
				rchk(IDX_FLAGS, 32'(m_flags));
			end
		end
		$display("end of edge test");
		apb(1'b1, IDX_MODE2, 32'h0);
		apb(1'b1, IDX_DATA_LO, 32'h5);
		apb(1'b1, IDX_DATA_HI, 32'hA);
		apb(1'b1, IDX_MODE2, 32'h6);
		apb(1'b1, IDX_FLAGS, 32'h0);
		pin_to(1'b1);
		apb(1'b0, IDX_DATA_HI, 32'h0);
		v = rd[3:0] * 16;
		apb(1'b0, IDX_DATA_LO, 32'h0);
		chk(32'(v + rd[3:0] <= 1), 32'h1);
		pin_to(1'b0);
		// A long clock-enable freeze must add no ticks to the measured interval.
		ce <= 1'b0;
		repeat (256) @(posedge clk_in);
		ce <= 1'b1;
		repeat (300) @(posedge clk_in);
		pin_to(1'b1);
		apb(1'b0, IDX_DATA_LO, 32'h0);
		v = rd[3:0];
		apb(1'b0, IDX_DATA_HI, 32'h0);
		v = v + rd[3:0] * 16;
		chk(32'(v >= 2 && v <= 3), 32'h1);
		m_flags = 7;
		rchk(IDX_FLAGS, 32'(m_flags));
		apb(1'b1, IDX_FLAGS, 32'h3);
		rchk(IDX_FLAGS, 32'h3);
		$display("end of capture test");
		for (int j = 0; j < 3; j++) begin
			apb(1'b1, IDX_PIN_FUNC, 32'(j != 0));
			apb(1'b1, IDX_CLK_GATE, 32'(j == 1));
			apb(1'b1, IDX_MODE2, j == 2 ? 32'h2 : 32'h6);
			apb(1'b1, IDX_FLAGS, 32'h0);
			pin_to(1'b0);
			pin_to(1'b1);
			rchk(IDX_FLAGS, 32'h0);
		end
		$display("end of refusal test");
		apb(1'b1, IDX_MODE1, 32'h7);
		apb(1'b1, IDX_DATA_LO, 32'h0);
		apb(1'b1, IDX_DATA_HI, 32'h0);
		for (int q = 0; q < 3; q++) begin
			pin_to(1'b0);
			pin_to(1'b1);
		end
		rchk(IDX_DATA_LO, 32'h3);
		apb(1'b1, IDX_MODE1, 32'h6);
		$display("end of event count test");
		apb(1'b1, IDX_PIN_FUNC, 32'h1);
		apb(1'b1, IDX_CLK_GATE, 32'h0);
		apb(1'b1, IDX_MODE2, 32'h7);
		apb(1'b0, IDX_IRQ_STAT, 32'h0);
		for (int m = 0; m < 2; m++) begin
			apb(1'b1, IDX_IRQ_MASK, m == 0 ? 32'h2 : 32'h0);
			apb(1'b1, IDX_FLAGS, 32'h0);
			pin_to(m[0]);
			chk({31'h0, irq}, 32'(m == 0));
			rchk(IDX_IRQ_STAT, 32'h2);
			@(posedge clk_in);
			chk({31'h0, irq}, 32'h0);
		end
		$display("end of interrupt test");
		reset_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		reset_in <= 1'b0;
		rchk(IDX_FLAGS, 32'h0);
		$display("end of second reset test");
		finish_test();
	end
endmodule : tb_tdc_timer
`default_nettype wire
